// ==== efi_pkg.sv ====
// package of constants and carrier types for the embedded frame information inserter
// assumes an 8-bit pixel stream and a 50 MHz core clock
//
// Overview of operation
// [RQ1] first metadata byte lands at column 0, row 0, then along the first row
// [RQ2] embedded values are those latched when shutter integration of the frame ended
// [RQ3] every item is one 32-bit word, four bytes, four 8-bit pixels
// [RQ4] all items enabled fill 40 bytes: timestamp at 0, gain 4, frame counter 24
// [RQ5] only enabled items are packed without gaps; a lone item takes bytes 0 to 3
// [RQ6] white balance word is still reserved when enabled, even with no valid contents
// [RQ7] timestamp cycle counter runs 0 to 7999, one pass per second
// [RQ8] seconds counter runs 0 to 127 and steps once per cycle-counter pass
// [RQ9] both timestamp counters wrap to zero instead of saturating
// [RQ10] optional 4-bit frame count replaces the low four cycle offset bits
// [RQ11] roi word: horizontal offset in first two bytes, vertical in next two
// [RQ12] each item has its own enable bit; disabled items leave pixels untouched
// [RQ13] timestamp word: seconds on top, then cycle count, then cycle offset
package efi_pkg;

    // ************************************************************
    // widths and item slots
    // ************************************************************
    localparam int PIX_W = 8;
    localparam int WORD_W = 32;
    localparam int N_ITEMS = 10;
    localparam int POS_W = 6;
    localparam logic [3:0] ITEM_TS = 4'h0;
    localparam logic [3:0] ITEM_GAIN = 4'h1;
    localparam logic [3:0] ITEM_SHUTTER = 4'h2;
    localparam logic [3:0] ITEM_BRIGHT = 4'h3;
    localparam logic [3:0] ITEM_WB = 4'h4;
    localparam logic [3:0] ITEM_AUX = 4'h5;
    localparam logic [3:0] ITEM_FRAME = 4'h6;
    localparam logic [3:0] ITEM_STROBE = 4'h7;
    localparam logic [3:0] ITEM_GPIO = 4'h8;
    localparam logic [3:0] ITEM_ROI = 4'h9;
    localparam logic [POS_W-1:0] POS_IDLE = 6'h3f;

    // ************************************************************
    // registers
    // ************************************************************
    localparam logic [31:0] SEL_ADDR = 32'h0000_12f8;
    localparam logic [31:0] FCNT_ADDR = 32'h0000_12fc;
    localparam int SEL_W = 11;
    localparam int SEL_OPT_BIT = 10;
    localparam logic [SEL_W-1:0] SEL_RESET = 11'h000;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ************************************************************
    // timestamp
    // ************************************************************
    localparam int CYC_W = 13;
    localparam int SEC_W = 7;
    localparam int OFF_W = 12;
    localparam int FC_IN_TS_W = 4;
    localparam logic [CYC_W-1:0] CYC_MAX = 13'h1f3f;
    localparam logic [SEC_W-1:0] SEC_MAX = 7'h7f;
    localparam int CLK_PERIOD_NS = 20;
    localparam int CYC_PERIOD_NS = 125000;
    localparam int CYC_CLKS = CYC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PRE_W = 13;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic sof;
        logic [PIX_W-1:0] data;
    } efi_pix_t;

    typedef struct packed {
        logic [WORD_W-1:0] gain;
        logic [WORD_W-1:0] shutter;
        logic [WORD_W-1:0] bright;
        logic [WORD_W-1:0] wb;
        logic [WORD_W-1:0] aux;
        logic [WORD_W-1:0] strobe;
        logic [WORD_W-1:0] gpio;
        logic [15:0] roi_x;
        logic [15:0] roi_y;
    } efi_live_t;

    typedef struct packed {
        logic [SEC_W-1:0] sec;
        logic [CYC_W-1:0] cyc;
        logic [OFF_W-1:0] off;
    } efi_ts_t;

    typedef logic [N_ITEMS-1:0][WORD_W-1:0] efi_words_t;

endpackage

// ==== efi_fifo.sv ====
// small synchronous fifo with a registered output stage
// assumes one clock; both sides use valid and ready
`timescale 1ns/10ps
`default_nettype none
module efi_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("efi_fifo depth must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic push;
    logic pop;

    assign push = in_valid_i && in_ready_o;
    // pop into the output register when it is empty or being drained
    assign pop = (cnt_q != '0) && (!out_valid_o || out_ready_i);

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + CW'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
            in_ready_o <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + AW'(1);
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + AW'(1);
            end
            cnt_q <= cnt_d;
            // ready is registered, so it looks at the next count
            in_ready_o <= (cnt_d != CW'(DEPTH));
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end else if (pop) begin
            out_valid_o <= 1'b1;
            out_data_o <= mem_q[rd_ptr_q];
        end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== efi_timestamp.sv ====
// free-running seconds / cycle / offset counters for the timestamp word
// assumes the core clock; one cycle lasts CYC_CLKS core clocks
`timescale 1ns/10ps
`default_nettype none
module efi_timestamp #(
    parameter int CYC_CLKS = efi_pkg::CYC_CLKS
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // running time
    output efi_pkg::efi_ts_t ts_o
);
    generate
        if (CYC_CLKS < 2 || CYC_CLKS > (1 << efi_pkg::PRE_W)) begin : g_bad_clks
            $error("efi_timestamp cycle length does not fit the prescaler");
        end
    endgenerate

    localparam logic [efi_pkg::PRE_W-1:0] PRE_MAX = efi_pkg::PRE_W'(CYC_CLKS - 1);

    logic [efi_pkg::PRE_W-1:0] pre_q;
    logic [efi_pkg::CYC_W-1:0] cyc_q;
    logic [efi_pkg::SEC_W-1:0] sec_q;
    logic tick;

    assign tick = (pre_q == PRE_MAX);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_q <= '0;
        end else if (tick) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + efi_pkg::PRE_W'(1);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cyc_q <= '0;
            sec_q <= '0;
        end else if (tick) begin
            if (cyc_q == efi_pkg::CYC_MAX) begin
                cyc_q <= '0; // [RQ7] [RQ9]
                if (sec_q == efi_pkg::SEC_MAX) begin
                    sec_q <= '0; // [RQ9]
                end else begin
                    sec_q <= sec_q + efi_pkg::SEC_W'(1); // [RQ8]
                end
            end else begin
                cyc_q <= cyc_q + efi_pkg::CYC_W'(1); // [RQ7]
            end
        end
    end

    // offset is the coarse position inside the current cycle
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ts_o <= '0;
        end else begin
            ts_o.sec <= sec_q;
            ts_o.cyc <= cyc_q;
            ts_o.off <= pre_q[efi_pkg::PRE_W-1 -: efi_pkg::OFF_W];
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_cycle_range: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        cyc_q <= efi_pkg::CYC_MAX) else $error("cycle count out of range"); // [RQ7]
    a_cycle_wrap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        tick && cyc_q == efi_pkg::CYC_MAX |=> cyc_q == '0 && sec_q == $past(sec_q) + efi_pkg::SEC_W'(1))
        else $error("cycle wrap did not advance seconds"); // [RQ8] [RQ9]
    a_sec_still: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !(tick && cyc_q == efi_pkg::CYC_MAX) |=> $stable(sec_q))
        else $error("seconds moved mid pass"); // [RQ8]
    c_sec_wrap: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        tick && cyc_q == efi_pkg::CYC_MAX && sec_q == efi_pkg::SEC_MAX);

endmodule
`default_nettype wire

// ==== efi_inserter.sv ====
// embedded frame information inserter: overwrites the first pixels of a frame
// assumes an 8-bit pixel stream with a start-of-frame flag on the first pixel,
// an integration-end pulse from the sensor timing and an ahb-lite register port
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module efi_inserter #(
    parameter int CYC_CLKS = efi_pkg::CYC_CLKS,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // per-frame parameters from the pipeline
    input wire logic integ_end_i,
    input wire efi_pkg::efi_live_t live_i,
    // pixels in
    input wire logic pix_valid_i,
    output logic pix_ready_o,
    input wire efi_pkg::efi_pix_t pix_i,
    // pixels out to the host stream
    output logic out_valid_o,
    input wire logic out_ready_i,
    output efi_pkg::efi_pix_t out_o
);
    generate
        if (FIFO_DEPTH < 2) begin : g_bad_depth
            $error("efi_inserter needs a fifo of at least two words");
        end
    endgenerate

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [3:0] count_en(input logic [efi_pkg::N_ITEMS-1:0] en);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < efi_pkg::N_ITEMS; i++) begin
            n = n + {3'h0, en[i]};
        end
        return n;
    endfunction

    // item index of the w-th enabled item, counted from the timestamp slot
    function automatic logic [3:0] nth_item(input logic [efi_pkg::N_ITEMS-1:0] en, input logic [3:0] w);
        logic [3:0] seen;
        logic [3:0] idx;
        seen = 4'h0;
        idx = 4'h0;
        for (int i = 0; i < efi_pkg::N_ITEMS; i++) begin
            if (en[i]) begin
                if (seen == w) begin
                    idx = 4'(i);
                end
                seen = seen + 4'h1;
            end
        end
        return idx;
    endfunction

    // ************************************************************
    // register port
    // ************************************************************
    logic [efi_pkg::SEL_W-1:0] sel_q;
    logic [31:0] frame_cnt_q;
    logic dp_write_q;
    logic [31:0] dp_addr_q;
    logic ap_take;
    logic wr_sel;
    logic [31:0] rd_d;

    assign ap_take = hsel_i && htrans_i[1] && hready_i;
    assign wr_sel = dp_write_q && (dp_addr_q == efi_pkg::SEL_ADDR);

    // read data is formed at the address phase, forwarding a write still in flight
    always_comb begin
        rd_d = 32'h0000_0000;
        if (haddr_i == efi_pkg::SEL_ADDR) begin
            rd_d = {21'h000000, wr_sel ? hwdata_i[efi_pkg::SEL_W-1:0] : sel_q};
        end else if (haddr_i == efi_pkg::FCNT_ADDR) begin
            rd_d = frame_cnt_q;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dp_write_q <= 1'b0;
            dp_addr_q <= 32'h0000_0000;
        end else if (hready_i) begin
            dp_write_q <= ap_take && hwrite_i && (hsize_i == efi_pkg::HSIZE_WORD);
            dp_addr_q <= haddr_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (ap_take && !hwrite_i) begin
            hrdata_o <= rd_d;
        end
    end

    // zero wait states, always okay; unmapped reads return zero
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_q <= efi_pkg::SEL_RESET;
        end else if (wr_sel) begin
            sel_q <= hwdata_i[efi_pkg::SEL_W-1:0]; // [RQ12]
        end
    end

    // ************************************************************
    // snapshot at end of integration
    // ************************************************************
    efi_pkg::efi_ts_t ts_now;
    efi_pkg::efi_ts_t ts_word;
    efi_pkg::efi_words_t live_words;
    efi_pkg::efi_words_t snap_q;
    efi_pkg::efi_words_t act_q;
    logic [efi_pkg::N_ITEMS-1:0] act_en_q;

    efi_timestamp #(
        .CYC_CLKS(CYC_CLKS)
    ) u_ts (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .ts_o(ts_now)
    );

    always_comb begin
        ts_word = ts_now;
        if (sel_q[efi_pkg::SEL_OPT_BIT]) begin
            ts_word.off[efi_pkg::FC_IN_TS_W-1:0] = frame_cnt_q[efi_pkg::FC_IN_TS_W-1:0]; // [RQ10]
        end
        live_words = '0;
        live_words[efi_pkg::ITEM_TS] = ts_word; // [RQ13]
        live_words[efi_pkg::ITEM_GAIN] = live_i.gain;
        live_words[efi_pkg::ITEM_SHUTTER] = live_i.shutter;
        live_words[efi_pkg::ITEM_BRIGHT] = live_i.bright;
        live_words[efi_pkg::ITEM_WB] = live_i.wb; // [RQ6]
        live_words[efi_pkg::ITEM_AUX] = live_i.aux;
        live_words[efi_pkg::ITEM_FRAME] = frame_cnt_q;
        live_words[efi_pkg::ITEM_STROBE] = live_i.strobe;
        live_words[efi_pkg::ITEM_GPIO] = live_i.gpio;
        live_words[efi_pkg::ITEM_ROI] = {live_i.roi_x, live_i.roi_y}; // [RQ11]
    end

    // later parameter changes cannot reach a frame already integrated
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            snap_q <= '0;
        end else if (integ_end_i) begin
            snap_q <= live_words; // [RQ2]
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_cnt_q <= 32'h0000_0000;
        end else if (integ_end_i) begin
            frame_cnt_q <= frame_cnt_q + 32'h0000_0001;
        end
    end

    // ************************************************************
    // insertion
    // ************************************************************
    logic accept;
    logic fifo_ready;
    logic [efi_pkg::POS_W-1:0] pos_q;
    logic [efi_pkg::POS_W-1:0] pos;
    logic [efi_pkg::POS_W-1:0] nbytes;
    logic [efi_pkg::N_ITEMS-1:0] cur_en;
    efi_pkg::efi_words_t cur_words;
    logic [3:0] item;
    logic [efi_pkg::WORD_W-1:0] word;
    logic insert;
    efi_pkg::efi_pix_t wr_pix;

    assign pix_ready_o = fifo_ready;
    assign accept = pix_valid_i && fifo_ready;
    assign cur_en = pix_i.sof ? sel_q[efi_pkg::N_ITEMS-1:0] : act_en_q;
    assign cur_words = pix_i.sof ? snap_q : act_q;
    assign pos = pix_i.sof ? '0 : pos_q; // [RQ1]
    assign nbytes = {count_en(cur_en), 2'b00}; // [RQ3] [RQ4]
    assign insert = (pos < nbytes); // [RQ5]
    assign item = nth_item(cur_en, pos[5:2]); // [RQ5]
    assign word = cur_words[item];

    // most significant byte of each word goes out first
    always_comb begin
        wr_pix = pix_i;
        if (insert) begin
            wr_pix.data = word[(3 - pos[1:0]) * efi_pkg::PIX_W +: efi_pkg::PIX_W]; // [RQ3]
        end
    end

    // a frame that starts before any sof is passed through untouched
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_q <= efi_pkg::POS_IDLE;
        end else if (accept) begin
            if (pix_i.sof) begin
                pos_q <= efi_pkg::POS_W'(1); // [RQ1]
            end else if (pos_q != efi_pkg::POS_IDLE) begin
                pos_q <= pos_q + efi_pkg::POS_W'(1);
            end
        end
    end

    // enables are frozen per frame so a mid-frame write cannot split a word
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_q <= '0;
            act_en_q <= '0;
        end else if (accept && pix_i.sof) begin
            act_q <= snap_q;
            act_en_q <= sel_q[efi_pkg::N_ITEMS-1:0];
        end
    end

    efi_fifo #(
        .WIDTH($bits(efi_pkg::efi_pix_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(pix_valid_i),
        .in_ready_o(fifo_ready),
        .in_data_i(wr_pix),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i),
        .out_data_o(out_o)
    );

    // ************************************************************
    // checks
    // ************************************************************
    a_first_ts_byte: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        accept && pix_i.sof && sel_q[efi_pkg::ITEM_TS] |-> wr_pix.data == snap_q[efi_pkg::ITEM_TS][31:24])
        else $error("timestamp not at pixel 0"); // [RQ1] [RQ4]
    a_snap_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !$past(integ_end_i) |-> $stable(snap_q))
        else $error("snapshot moved without integration end"); // [RQ2]
    a_pass_after: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        accept && !pix_i.sof && pos_q >= nbytes |-> wr_pix == pix_i)
        else $error("pixel past metadata modified"); // [RQ3] [RQ12]
    a_lone_shutter: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        accept && pix_i.sof && sel_q[efi_pkg::N_ITEMS-1:0] == 10'h004
        |-> wr_pix.data == snap_q[efi_pkg::ITEM_SHUTTER][31:24])
        else $error("lone shutter not packed first"); // [RQ5]
    a_frame_slot: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        accept && !pix_i.sof && act_en_q == 10'h3ff && pos_q == 6'h18
        |-> wr_pix.data == act_q[efi_pkg::ITEM_FRAME][31:24])
        else $error("frame counter not at byte 24"); // [RQ4]
    a_wb_slot: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        accept && pix_i.sof && sel_q[efi_pkg::N_ITEMS-1:0] == 10'h010
        |-> wr_pix.data == snap_q[efi_pkg::ITEM_WB][31:24])
        else $error("white balance word not reserved"); // [RQ6]
    a_roi_layout: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        integ_end_i |=> snap_q[efi_pkg::ITEM_ROI] == {$past(live_i.roi_x), $past(live_i.roi_y)})
        else $error("roi word layout wrong"); // [RQ11]
    a_ts_pack: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        integ_end_i |=> snap_q[efi_pkg::ITEM_TS][31:25] == $past(ts_now.sec)
        && snap_q[efi_pkg::ITEM_TS][24:12] == $past(ts_now.cyc))
        else $error("timestamp word packing wrong"); // [RQ13]
    a_fc_in_ts: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        integ_end_i && sel_q[efi_pkg::SEL_OPT_BIT]
        |=> snap_q[efi_pkg::ITEM_TS][3:0] == $past(frame_cnt_q[3:0]))
        else $error("frame count missing from offset"); // [RQ10]
    a_none_pass: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        accept && cur_en == '0 |-> wr_pix == pix_i)
        else $error("pixels modified with nothing enabled"); // [RQ12]

    c_all_items: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        accept && !pix_i.sof && act_en_q == 10'h3ff && pos_q == 6'h27);
    c_fifo_full: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pix_valid_i && !fifo_ready);
    c_reg_write: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) wr_sel);

endmodule
`default_nettype wire

// ==== efi_host_model.sv ====
// host-side sink for the outgoing pixel stream, keeps every pixel it takes
// assumes the inserter's out valid/ready handshake on the core clock
`timescale 1ns/10ps
`default_nettype none
module efi_host_model (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // stream from the inserter
    input wire logic valid_i,
    input wire efi_pkg::efi_pix_t pix_i,
    input wire logic stall_i,
    output logic ready_o
);
    efi_pkg::efi_pix_t got_q[$];
    // ************
    // half-rate ready while stalled, so the fifo backs up
    // ************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= stall_i ? ~ready_o : 1'b1;
        end
    end
    always @(posedge core_clk_i) begin
        if (valid_i && ready_o) begin
            got_q.push_back(pix_i);
        end
    end
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the embedded frame information inserter
// assumes efi_pkg, the fifo, timestamp and the host model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0;
    logic hreadyout_o, hresp_o, out_valid_o, pix_ready_o, out_ready_i, ok;
    logic [31:0] hrdata_o, rd;
    logic integ_end_i = 1'b0;
    logic pix_valid_i = 1'b0;
    logic stall = 1'b0;
    logic saw_full = 1'b0;
    logic [31:0] fc = 32'h0;
    efi_pkg::efi_live_t live_i = '0;
    efi_pkg::efi_live_t la = {32'ha1a2a3a4, 32'hb1b2b3b4, 32'hc1c2c3c4, 32'hd1d2d3d4, 32'he1e2e3e4,
        32'hf1f2f3f4, 32'h01020304, 16'h0123, 16'h0456};
    efi_pkg::efi_pix_t pix_i = '0;
    efi_pkg::efi_pix_t out_o;
    int miscompares = 0;
    int check_count = 0;
    always #10 core_clk_i = ~core_clk_i;
    // short timestamp cycle keeps the run small
    efi_inserter #(.CYC_CLKS(4)) u_dut (.core_clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i, .hready_i(hreadyout_o), .hwdata_i, .hreadyout_o, .hresp_o, .hrdata_o, .integ_end_i,
        .live_i, .pix_valid_i, .pix_ready_o, .pix_i, .out_valid_o, .out_ready_i, .out_o);
    efi_host_model u_host (.core_clk_i, .rst_n_i, .valid_i(out_valid_o), .pix_i(out_o),
        .stall_i(stall), .ready_o(out_ready_i));
    always @(posedge core_clk_i) if (rst_n_i && pix_valid_i && !pix_ready_o) saw_full <= 1'b1;
    // ************
    // shared tasks
    // ************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ready is sampled half a cycle early: it only moves on rising edges
    task automatic step_hi(input int w);
        do begin
            @(negedge core_clk_i);
            ok = (w == 0) ? hreadyout_o : pix_ready_o;
            rd = hrdata_o;
            @(posedge core_clk_i);
        end while (ok !== 1'b1);
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        haddr_i <= a;
        step_hi(0);
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= wd;
        step_hi(0);
        chk(32'(hresp_o), 32'h0);
    endtask
    task automatic integ();
        live_i <= la;
        @(posedge core_clk_i);
        integ_end_i <= 1'b1;
        @(posedge core_clk_i);
        integ_end_i <= 1'b0;
        live_i <= ~la;
    endtask
    task automatic frame(input int n);
        u_host.got_q.delete();
        for (int k = 0; k < n; k++) begin
            pix_valid_i <= 1'b1;
            pix_i <= {k == 0, 8'h80 + 8'(k)};
            step_hi(1);
        end
        pix_valid_i <= 1'b0;
        repeat (400) if (u_host.got_q.size() < n) @(posedge core_clk_i);
    endtask
    function automatic logic [31:0] wd_at(input int b);
        return {u_host.got_q[b].data, u_host.got_q[b+1].data, u_host.got_q[b+2].data, u_host.got_q[b+3].data};
    endfunction
    function automatic logic [31:0] pass_at(input int b);
        return {8'h80 + 8'(b), 8'h81 + 8'(b), 8'h82 + 8'(b), 8'h83 + 8'(b)};
    endfunction
    function automatic logic [31:0] exp_item(input int i);
        return (i == 6) ? fc : la[255 - 32 * (i - (i > 6 ? 2 : 1)) -: 32];
    endfunction
    // ************
    // scenarios
    // ************
    task automatic t_regs();
        ahb(1'b0, 32'h12f8, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b1, 32'h12f8, 32'hffff_ffff);
        ahb(1'b0, 32'h12f8, 32'h0);
        chk(rd, 32'h7ff);
        ahb(1'b0, 32'h1300, 32'h0);
        chk(rd, 32'h0);
        $display("regs done");
    endtask
    task automatic t_single();
        for (int i = 1; i < 10; i++) begin
            integ();
            ahb(1'b1, 32'h12f8, 32'(1) << i);
            frame(8);
            chk(wd_at(0), exp_item(i));
            chk(wd_at(4), pass_at(4));
            fc++;
        end
        ahb(1'b0, 32'h12fc, 32'h0);
        chk(rd, fc);
        $display("single items done");
    endtask
    task automatic t_all();
        integ();
        ahb(1'b1, 32'h12f8, 32'h3ff);
        stall <= 1'b1;
        frame(44);
        stall <= 1'b0;
        chk(32'(u_host.got_q[0].sof), 32'h1);
        chk(32'(wd_at(0) >> 25), 32'h0);
        chk(32'(((wd_at(0) >> 12) & 32'h0000_1fff) < 32'h0000_1f40), 32'h1);
        chk(wd_at(4), la.gain);
        chk(wd_at(24), fc);
        chk(wd_at(36), {la.roi_x, la.roi_y});
        chk(wd_at(40), pass_at(40));
        chk(32'(saw_full), 32'h1);
        $display("all items done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        t_regs();
        t_single();
        t_all();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
